/* hdl/freq_counter_pkg.sv */
// Shared constants, types and helpers for the gated frequency counter.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package freq_counter_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_CONFIG       = 8'h04;
  localparam logic [7:0] OFS_GATE_WIDTH   = 8'h08;
  localparam logic [7:0] OFS_GATE_LIMIT   = 8'h0c;
  localparam logic [7:0] OFS_STATUS       = 8'h10;
  localparam logic [7:0] OFS_COUNT        = 8'h14;
  localparam logic [7:0] OFS_ACTUAL_WIDTH = 8'h18;
  localparam logic [7:0] OFS_FREQUENCY    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h24;

  // Control command bits, self clearing
  localparam int CTL_MEASURE = 0;
  localparam int CTL_START   = 1;
  localparam int CTL_STOP    = 2;
  localparam int CTL_READ    = 3;

  // Configuration fields
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_CASCADE     = 2;
  localparam int CFG_EVENT_SEL   = 3;
  localparam int CFG_COUNTER_LSB = 4;

  // Status fields
  localparam int ST_BUSY        = 0;
  localparam int ST_OVERFLOW    = 1;
  localparam int ST_VALID       = 2;
  localparam int ST_TIMEOUT     = 3;
  localparam int ST_GATE        = 4;
  localparam int ST_RUN         = 5;
  localparam int ST_PARTNER_LSB = 8;

  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF  = 1;
  localparam int IRQ_TMO  = 2;
  localparam int IRQ_W    = 3;

  // Values after reset
  localparam logic [7:0]  CONFIG_RESET     = 8'h10;
  localparam logic [31:0] GATE_WIDTH_RESET = 32'h0000_2710;
  localparam logic [31:0] GATE_LIMIT_RESET = 32'h0000_2710;

  // Cycle counts
  localparam logic [1:0] MIN_DELAY_CYCLES = 2'h3;
  localparam logic [6:0] DIV_LAST         = 7'h3f;

  // Counter widths per variant
  localparam int NARROW_W  = 16;
  localparam int WIDE_W    = 24;
  localparam int CASCADE_W = 32;

  // Trigger modes of the gate counter
  typedef enum logic [1:0] {
    free_start_mode = 2'h0,
    gate_high_mode  = 2'h1,
    gate_low_mode   = 2'h2,
    gate_rise_mode  = 2'h3
  } gate_mode_t;

  // Measurement sequencer, Gray coded along the main path
  typedef enum logic [2:0] {
    idle_st  = 3'h0,
    arm_st   = 3'h1,
    wait_st  = 3'h3,
    pulse_st = 3'h2,
    poll_st  = 3'h6,
    capt_st  = 3'h7,
    div_st   = 3'h5,
    done_st  = 3'h4
  } meas_state_t;

  // Terminal count mask for a counter of the given width
  function automatic logic [31:0] limit_mask(input int width);
    logic [63:0] full;
    full = (64'h1 << width) - 64'h1;
    return full[31:0];
  endfunction

  // Cascade partner within a group of five
  function automatic logic [3:0] counter_plus_one(input logic [3:0] c);
    if (c == 4'h5) begin
      return 4'h1;
    end else if (c == 4'ha) begin
      return 4'h6;
    end else begin
      return c + 4'h1;
    end
  endfunction

  // Merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* hdl/event_counter.sv */
// Edge counter with programmable terminal count and sticky overflow.
// Assumes edge_in is a one-cycle pulse already synchronised to clock_in.
`timescale 1ns/1ns
`default_nettype none
module event_counter #(
  parameter int MAX_W = 32
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  input  wire logic             enable_in,
  input  wire logic             edge_in,
  input  wire logic [MAX_W-1:0] limit_in,
  output logic      [MAX_W-1:0] count_out,
  output logic                  overflow_out
);

  // Refuse widths the arithmetic cannot hold
  if (MAX_W < 1 || MAX_W > 32) begin : g_bad_width
    $error("event_counter: MAX_W must lie in 1..32");
  end

  wire logic             hit;        // Counted edge this cycle
  wire logic             at_limit;   // Count sits on terminal count
  wire logic [MAX_W-1:0] next_count; // Incremented or wrapped value

  assign hit        = edge_in & enable_in;
  assign at_limit   = (count_out == limit_in);
  assign next_count = at_limit ? '0 : count_out + 1'b1;

  // Count register; clear wins so a fresh run starts from zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= '0;
    end else if (clear_in) begin
      count_out <= '0;
    end else if (hit) begin
      count_out <= next_count;
    end
  end

  // Sticky flag; rolling past terminal count spoils the result
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_out <= 1'b0;
    end else if (clear_in) begin
      overflow_out <= 1'b0;
    end else if (hit && at_limit) begin
      overflow_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* hdl/gated_frequency_counter.sv */
// Gated frequency counter: event counter gated by a one-shot gate counter.
// Assumes pins are asynchronous TTL levels and an Avalon-MM master.
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module gated_frequency_counter #(
  parameter int CLK_HZ       = 100_000_000,
  parameter bit WIDE_VARIANT = 1'b1
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  input  wire logic        source0_in,
  input  wire logic        source1_in,
  input  wire logic        gate0_in,
  input  wire logic        gate1_in,
  output logic             out0_out,
  output logic             out1_out,
  output logic             irq_out
);

  // Refuse clock rates the frequency arithmetic cannot hold
  if (CLK_HZ <= 0) begin : g_bad_clock
    $error("gated_frequency_counter: CLK_HZ must be positive");
  end

  // Pin synchronisers: stage a feeds only stage b
  logic [3:0] sync_a;  // First stage, metastable
  logic [3:0] sync_b;  // Second stage, safe level
  logic [3:0] sync_c;  // Delayed copy for edge detection

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sync_c <= 4'h0;
    end else begin
      sync_a <= {gate1_in, gate0_in, source1_in, source0_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  wire logic [3:0] rise = sync_b & ~sync_c;  // Rising edge pulses

  localparam int IRQ_W = freq_counter_pkg::IRQ_W;  // Interrupt sources, declared before use

  // Software visible registers
  logic [7:0]       config_reg;   // Mode, cascade, event select, counter number
  logic [31:0]      gate_width;   // Requested gate pulse width, cycles
  logic [31:0]      gate_limit;   // Longest wait for gate start, cycles
  logic [IRQ_W-1:0] irq_status;   // Sticky events, write one to clear
  logic [IRQ_W-1:0] irq_mask;     // Interrupt enables
  logic             run;          // Free counting started by software

  // Sequencer and result state
  freq_counter_pkg::meas_state_t state;
  freq_counter_pkg::meas_state_t next_state;
  logic [31:0] tick;          // Timeout or gate width progress
  logic [31:0] next_tick;
  logic [1:0]  delay;         // Minimum delay before the pulse
  logic [1:0]  next_delay;
  logic        timeout_flag;  // Gate did not start in time
  logic        next_timeout;
  logic        next_gate;     // Gate counter output, next value
  logic [31:0] act_width;     // Cycles the gate really stood high
  logic [31:0] count_reg;     // Captured or snapshot count
  logic        ovf_reg;       // Overflow of that count
  logic        valid_flag;    // Measurement clean
  logic [31:0] freq_reg;      // Edges per second
  logic [63:0] num;           // Divider dividend, then quotient
  logic [32:0] rem;           // Divider partial remainder
  logic [6:0]  div_step;      // Divider iteration

  // Bus handshake: one wait cycle, then the access completes
  wire logic wr_go = write_in & ~waitrequest_out;
  wire logic rd_go = read_in & waitrequest_out;

  // Address decode
  wire logic hit_ctrl  = (address_in == freq_counter_pkg::OFS_CONTROL);
  wire logic hit_cfg   = (address_in == freq_counter_pkg::OFS_CONFIG);
  wire logic hit_width = (address_in == freq_counter_pkg::OFS_GATE_WIDTH);
  wire logic hit_limit = (address_in == freq_counter_pkg::OFS_GATE_LIMIT);
  wire logic hit_stat  = (address_in == freq_counter_pkg::OFS_STATUS);
  wire logic hit_count = (address_in == freq_counter_pkg::OFS_COUNT);
  wire logic hit_act   = (address_in == freq_counter_pkg::OFS_ACTUAL_WIDTH);
  wire logic hit_freq  = (address_in == freq_counter_pkg::OFS_FREQUENCY);
  wire logic hit_irqs  = (address_in == freq_counter_pkg::OFS_IRQ_STATUS);
  wire logic hit_irqm  = (address_in == freq_counter_pkg::OFS_IRQ_MASK);

  // Command pulses from the control register, low byte only
  wire logic ctl_wr = wr_go & hit_ctrl & byteenable_in[0];
  wire logic measure_frequency_cmd = ctl_wr & writedata_in[freq_counter_pkg::CTL_MEASURE];
  wire logic start_count_cmd       = ctl_wr & writedata_in[freq_counter_pkg::CTL_START];
  wire logic stop_count_cmd        = ctl_wr & writedata_in[freq_counter_pkg::CTL_STOP];
  wire logic read_count_cmd        = ctl_wr & writedata_in[freq_counter_pkg::CTL_READ];

  // Configuration fields
  wire logic [1:0] mode_bits  = config_reg[freq_counter_pkg::CFG_MODE_LSB +: 2];
  wire logic       cascade    = config_reg[freq_counter_pkg::CFG_CASCADE];
  wire logic       event_sel  = config_reg[freq_counter_pkg::CFG_EVENT_SEL];
  wire logic [3:0] counter_no = config_reg[freq_counter_pkg::CFG_COUNTER_LSB +: 4];
  wire freq_counter_pkg::gate_mode_t gate_counter_trigger_mode =
    freq_counter_pkg::gate_mode_t'(mode_bits);

  // Gate counter is the opposite counter
  wire logic gate_pin  = event_sel ? sync_b[2] : sync_b[3];
  wire logic gate_edge = event_sel ? rise[2] : rise[3];
  wire logic src_rise  = event_sel ? rise[1] : rise[0];
  wire logic gate_level = out0_out | out1_out;

  // Trigger modes of the gate counter
  wire logic trig_go =
    (gate_counter_trigger_mode == freq_counter_pkg::free_start_mode) ? 1'b1 :
    (gate_counter_trigger_mode == freq_counter_pkg::gate_high_mode)  ? gate_pin :
    (gate_counter_trigger_mode == freq_counter_pkg::gate_low_mode)   ? ~gate_pin :
    gate_edge;
  wire logic gate_active =
    (gate_counter_trigger_mode == freq_counter_pkg::gate_high_mode) ? gate_pin :
    (gate_counter_trigger_mode == freq_counter_pkg::gate_low_mode)  ? ~gate_pin :
    1'b1;
  wire logic [31:0] width_target = (gate_width == 32'h0) ? 32'h1 : gate_width;

  // Terminal count by variant and cascade
  wire logic [31:0] count_limit = WIDE_VARIANT ? freq_counter_pkg::limit_mask(freq_counter_pkg::WIDE_W) :
    cascade ? freq_counter_pkg::limit_mask(freq_counter_pkg::CASCADE_W) :
    freq_counter_pkg::limit_mask(freq_counter_pkg::NARROW_W);

  // Cascade partner, or gate counter number
  wire logic [3:0] partner = WIDE_VARIANT ? {3'h0, ~event_sel} :
    freq_counter_pkg::counter_plus_one(counter_no);

  // Event counter: cleared on arm or start, enabled by gate or run
  wire logic [31:0] ev_count;
  wire logic        ev_ovf;
  wire logic        ev_enable = gate_level | run;
  wire logic        ev_clear  = (state == freq_counter_pkg::arm_st) | start_count_cmd;

  event_counter #(
    .MAX_W (32)
  ) u_event (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .clear_in     (ev_clear),
    .enable_in    (ev_enable),
    .edge_in      (src_rise),
    .limit_in     (count_limit),
    .count_out    (ev_count),
    .overflow_out (ev_ovf)
  );

  // Sequencer next state
  always_comb begin
    next_state   = state;
    next_tick    = tick;
    next_delay   = delay;
    next_timeout = timeout_flag;
    next_gate    = gate_level;
    case (state)
      freq_counter_pkg::idle_st: begin
        if (measure_frequency_cmd) begin
          next_state = freq_counter_pkg::arm_st;
        end
      end
      freq_counter_pkg::arm_st: begin
        next_tick    = 32'h0;
        next_timeout = 1'b0;
        next_state   = freq_counter_pkg::wait_st;
      end
      freq_counter_pkg::wait_st: begin
        if (trig_go) begin
          next_delay = freq_counter_pkg::MIN_DELAY_CYCLES;
          next_tick  = 32'h0;
          next_state = freq_counter_pkg::pulse_st;
        end else if (tick >= gate_limit) begin
          next_timeout = 1'b1;
          next_state   = freq_counter_pkg::capt_st;
        end else begin
          next_tick = tick + 32'h1;
        end
      end
      freq_counter_pkg::pulse_st: begin
        if (delay != 2'h0) begin
          next_delay = delay - 2'h1;
        end else if (!gate_level) begin
          next_gate = 1'b1;
        end else if (gate_active) begin
          if (tick + 32'h1 >= width_target) begin
            next_gate  = 1'b0;
            next_state = freq_counter_pkg::poll_st;
          end else begin
            next_tick = tick + 32'h1;
          end
        end
      end
      freq_counter_pkg::poll_st: begin
        if (!gate_level) begin
          next_state = freq_counter_pkg::capt_st;
        end
      end
      freq_counter_pkg::capt_st: begin
        next_state = freq_counter_pkg::div_st;
      end
      freq_counter_pkg::div_st: begin
        if (div_step == freq_counter_pkg::DIV_LAST) begin
          next_state = freq_counter_pkg::done_st;
        end
      end
      default: begin
        next_state = freq_counter_pkg::idle_st;
      end
    endcase
    if (stop_count_cmd) begin
      next_state = freq_counter_pkg::idle_st;
      next_gate  = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state        <= freq_counter_pkg::idle_st;
      tick         <= 32'h0;
      delay        <= 2'h0;
      timeout_flag <= 1'b0;
      out0_out     <= 1'b0;
      out1_out     <= 1'b0;
    end else begin
      state        <= next_state;
      tick         <= next_tick;
      delay        <= next_delay;
      timeout_flag <= next_timeout;
      out0_out     <= next_gate & event_sel;
      out1_out     <= next_gate & ~event_sel;
    end
  end

  // Divider step: restoring, one quotient bit per cycle
  wire logic [32:0] shifted = {rem[31:0], num[63]};
  wire logic        fits    = (shifted >= {1'b0, act_width});
  wire logic [32:0] next_rem = fits ? shifted - {1'b0, act_width} : shifted;
  wire logic [63:0] dividend = {32'h0, ev_count} * {32'h0, 32'(CLK_HZ)};

  // Actual width and divider
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      act_width <= 32'h0;
      num       <= 64'h0;
      rem       <= 33'h0;
      div_step  <= 7'h0;
    end else if (state == freq_counter_pkg::arm_st) begin
      act_width <= 32'h0;
    end else if (gate_level) begin
      act_width <= act_width + 32'h1;
    end else if (state == freq_counter_pkg::capt_st) begin
      num      <= dividend;
      rem      <= 33'h0;
      div_step <= 7'h0;
    end else if (state == freq_counter_pkg::div_st) begin
      num      <= {num[62:0], fits};
      rem      <= next_rem;
      div_step <= div_step + 7'h1;
    end
  end

  // Results: capture, snapshot and flags
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg  <= 32'h0;
      ovf_reg    <= 1'b0;
      valid_flag <= 1'b0;
      freq_reg   <= 32'h0;
    end else if (state == freq_counter_pkg::arm_st) begin
      valid_flag <= 1'b0;
    end else if (state == freq_counter_pkg::capt_st) begin
      count_reg  <= ev_count;
      ovf_reg    <= ev_ovf;
      valid_flag <= ~ev_ovf;
    end else if (state == freq_counter_pkg::done_st) begin
      freq_reg <= (act_width == 32'h0) ? 32'h0 :
                  (|num[63:32]) ? 32'hffff_ffff : num[31:0];
    end else if (read_count_cmd) begin
      count_reg <= ev_count;
      ovf_reg   <= ev_ovf;
    end
  end

  // Free counting run flag
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      run <= 1'b0;
    end else if (stop_count_cmd) begin
      run <= 1'b0;
    end else if (start_count_cmd) begin
      run <= 1'b1;
    end
  end

  // Interrupt events; a set in the clearing cycle survives
  wire logic [IRQ_W-1:0] irq_events = {
    next_timeout & ~timeout_flag,
    (state == freq_counter_pkg::capt_st) & ev_ovf,
    (state == freq_counter_pkg::done_st)};
  wire logic [IRQ_W-1:0] irq_clear =
    (wr_go & hit_irqs & byteenable_in[0]) ? writedata_in[IRQ_W-1:0] : '0;
  wire logic [IRQ_W-1:0] next_irq = (irq_status & ~irq_clear) | irq_events;

  // Writable registers with byte enables
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      config_reg <= freq_counter_pkg::CONFIG_RESET;
      gate_width <= freq_counter_pkg::GATE_WIDTH_RESET;
      gate_limit <= freq_counter_pkg::GATE_LIMIT_RESET;
      irq_mask   <= '0;
      irq_status <= '0;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_irq;
      irq_out    <= |(next_irq & irq_mask);
      if (wr_go && hit_cfg && byteenable_in[0]) begin
        config_reg <= writedata_in[7:0];
      end
      if (wr_go && hit_width) begin
        gate_width <= freq_counter_pkg::be_merge(gate_width, writedata_in, byteenable_in);
      end
      if (wr_go && hit_limit) begin
        gate_limit <= freq_counter_pkg::be_merge(gate_limit, writedata_in, byteenable_in);
      end
      if (wr_go && hit_irqm && byteenable_in[0]) begin
        irq_mask <= writedata_in[IRQ_W-1:0];
      end
    end
  end

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[freq_counter_pkg::ST_BUSY]     = (state != freq_counter_pkg::idle_st);
    status_word[freq_counter_pkg::ST_OVERFLOW] = ovf_reg;
    status_word[freq_counter_pkg::ST_VALID]    = valid_flag;
    status_word[freq_counter_pkg::ST_TIMEOUT]  = timeout_flag;
    status_word[freq_counter_pkg::ST_GATE]     = gate_level;
    status_word[freq_counter_pkg::ST_RUN]      = run;
    status_word[freq_counter_pkg::ST_PARTNER_LSB +: 4] = partner;
  end

  // Read mux; unmapped and write-only addresses read zero
  wire logic [31:0] rd_mux =
    hit_cfg   ? {24'h0, config_reg} :
    hit_width ? gate_width :
    hit_limit ? gate_limit :
    hit_stat  ? status_word :
    hit_count ? count_reg :
    hit_act   ? act_width :
    hit_freq  ? freq_reg :
    hit_irqs  ? {29'h0, irq_status} :
    hit_irqm  ? {29'h0, irq_mask} :
    32'h0;

  // Bus answer: drop waitrequest one cycle after a request
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      waitrequest_out <= 1'b1;
      readdata_out    <= 32'h0;
    end else begin
      waitrequest_out <= ~(waitrequest_out & (read_in | write_in));
      if (rd_go) begin
        readdata_out <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

/* verif/freq_counter_props.sv */
// Port checker for the gated frequency counter.
// Assumes it is bound to each gated_frequency_counter.
`timescale 1ns/1ns
`default_nettype none
module freq_counter_props (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [7:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0]  byteenable_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        source0_in,
  input wire logic        source1_in,
  input wire logic        gate0_in,
  input wire logic        gate1_in,
  input wire logic        out0_out,
  input wire logic        out1_out,
  input wire logic        irq_out
);
  wire         gate = out0_out || out1_out;        // Any gate pin high
  wire         acc  = write_in && !waitrequest_out; // Write taking effect
  wire         ctl  = acc && address_in == freq_counter_pkg::OFS_CONTROL;
  logic [31:0] width;  // Programmed gate width
  logic [31:0] hi_cnt; // Cycles the gate stood high
  logic        cut;    // Stop seen, so a short pulse is fine
  logic        armed = 1'b0; // Past the first edge, reset flops settled
  // Shadow width; a stop may legally shorten the pulse
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      width  <= freq_counter_pkg::GATE_WIDTH_RESET;
      hi_cnt <= 32'h0;
      cut    <= 1'b0;
    end else begin
      if (acc && address_in == freq_counter_pkg::OFS_GATE_WIDTH) width <= writedata_in;
      hi_cnt <= gate ? hi_cnt + 32'h1 : 32'h0;
      cut    <= (ctl && writedata_in[2]) || (cut && gate);
    end
  end
  // Reset flops only settle at the first edge, so skip it
  always @(posedge clock_in) armed <= 1'b1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_in && armed |-> !gate && !irq_out && waitrequest_out) else $error("active in reset");
  a_one_gate: assert property (!(out0_out && out1_out)) else $error("two gates");
  a_wait_single: assert property (!waitrequest_out |=> waitrequest_out) else $error("long ack");
  a_wait_answer: assert property ((read_in || write_in) && waitrequest_out |=>
    !waitrequest_out) else $error("no ack");
  a_gate_delay: assert property (ctl && writedata_in[0] |=> !gate [*3])
    else $error("gate too soon");
  a_stop_halts: assert property (ctl && writedata_in[2] |-> ##[1:2] !gate)
    else $error("gate after stop");
  a_pulse_width: assert property ($fell(gate) |-> hi_cnt >= width || cut)
    else $error("gate short");
  a_irq_masked: assert property (acc && address_in == freq_counter_pkg::OFS_IRQ_MASK &&
    writedata_in[2:0] == 3'h0 |-> ##[1:2] !irq_out) else $error("irq while masked");
endmodule
bind gated_frequency_counter freq_counter_props freq_counter_props_inst (.clock_in,
  .rst_in, .address_in, .read_in, .write_in, .writedata_in, .byteenable_in,
  .readdata_out, .waitrequest_out, .source0_in, .source1_in, .gate0_in, .gate1_in,
  .out0_out, .out1_out, .irq_out);
`default_nettype wire

/* verif/signal_source_model.sv */
// Measured square wave and external gate trigger.
// Assumes a half period of at least one clock.
`timescale 1ns/1ns
`default_nettype none
module signal_source_model (
  input  wire logic       clock_in,
  input  wire logic [2:0] half_in,
  input  wire logic       trig_in,
  output logic            source_out,
  output logic            gate_out
);
  logic [2:0] tick = 3'h0; // Cycles into this half
  initial source_out = 1'b0;
  // Toggle each half period
  always @(posedge clock_in) begin
    tick <= (tick >= half_in - 3'h1) ? 3'h0 : tick + 3'h1;
    if (tick >= half_in - 3'h1) source_out <= !source_out;
  end
  always @(posedge clock_in) gate_out <= trig_in;
endmodule
`default_nettype wire

/* verif/gated_frequency_counter_test.sv */
// Bench for the gated frequency counter.
// Assumes the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
module gated_frequency_counter_test;
  logic        clock_in = 1'b0, rst_in = 1'b1, read_in = 1'b0, write_in = 1'b0;
  logic [7:0]  address_in = 8'h0;
  logic [31:0] writedata_in = 32'h0, readdata_out, q, cnt;
  logic [3:0]  byteenable_in = 4'hf;
  logic        waitrequest_out, src, gate, trig = 1'b0, out0_out, out1_out, irq_out;
  logic [2:0]  half = 3'h1;
  int          errors = 0, n_tests = 0, seed = 32'h4484623e, w, lo;
  gated_frequency_counter gated_frequency_counter_inst (.clock_in, .rst_in, .address_in,
    .read_in, .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out,
    .source0_in(src), .source1_in(src), .gate0_in(gate), .gate1_in(gate), .out0_out,
    .out1_out, .irq_out);
  signal_source_model signal_source_model_inst (.clock_in, .half_in(half), .trig_in(trig),
    .source_out(src), .gate_out(gate));
  always #5 clock_in = !clock_in;
  task automatic results;
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One bus transfer, held until acknowledged
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int t;
    t = 0;
    @(posedge clock_in);
    address_in <= a;
    write_in <= wr;
    read_in <= !wr;
    writedata_in <= d;
    byteenable_in <= be;
    do @(posedge clock_in); while (waitrequest_out !== 1'b0 && ++t < 50);
    if (t >= 50) errors++;
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask
  // Saturating count times clock over width
  function automatic logic [31:0] freq(input logic [31:0] c, input logic [31:0] wd);
    logic [63:0] f;
    f = (64'(c) * 64'h5f5e100) / 64'(wd);
    return (f > 64'hffffffff) ? 32'hffffffff : f[31:0];
  endfunction
  // Configure, trigger and wait for completion
  task automatic measure(input logic [1:0] m, input logic sel, input logic tg);
    int t;
    t = 0;
    bus(1'b1, freq_counter_pkg::OFS_CONFIG, {24'h0, 4'h1, sel, 1'b0, m}, 4'hf);
    trig <= 1'b0;
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h1, 4'hf);
    trig <= tg;
    do bus(1'b0, freq_counter_pkg::OFS_STATUS, 32'h0, 4'hf);
    while (q[0] !== 1'b0 && ++t < 300);
    if (t >= 300) errors++;
  endtask
  initial begin
    repeat (20000) @(posedge clock_in);
    errors++;
    results;
  end
  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    rchk("config", freq_counter_pkg::OFS_CONFIG, 32'h10);
    rchk("width", freq_counter_pkg::OFS_GATE_WIDTH, 32'h2710);
    rchk("count", freq_counter_pkg::OFS_COUNT, 32'h0);
    rchk("unmapped", 8'h30, 32'h0);
    bus(1'b0, freq_counter_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk("flags", 32'h0, q & 32'hff);
    bus(1'b1, freq_counter_pkg::OFS_GATE_LIMIT, 32'h12345678, 4'h5);
    rchk("limit", freq_counter_pkg::OFS_GATE_LIMIT, 32'h00342778);
    for (int m = 0; m < 4; m++) begin
      half <= 3'h1 + 3'($random(seed) & 3);
      w = 40 + ($random(seed) & 63);
      bus(1'b1, freq_counter_pkg::OFS_GATE_WIDTH, w, 4'hf);
      measure(m[1:0], m[0], m != 2);
      rchk("status", freq_counter_pkg::OFS_STATUS, m[0] ? 32'h4 : 32'h104);
      rchk("actual", freq_counter_pkg::OFS_ACTUAL_WIDTH, w);
      bus(1'b0, freq_counter_pkg::OFS_COUNT, 32'h0, 4'hf);
      cnt = q;
      lo = w / (2 * half);
      chk("count", 32'h1, {31'h0, cnt + 1 >= lo && cnt <= lo + 1});
      rchk("freq", freq_counter_pkg::OFS_FREQUENCY, freq(cnt, w));
    end
    rchk("irq_status", freq_counter_pkg::OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, freq_counter_pkg::OFS_IRQ_MASK, 32'h7, 4'hf);
    repeat (2) @(posedge clock_in);
    chk("irq", 32'h1, {31'h0, irq_out});
    bus(1'b1, freq_counter_pkg::OFS_IRQ_STATUS, 32'h1, 4'hf);
    repeat (2) @(posedge clock_in);
    chk("irq", 32'h0, {31'h0, irq_out});
    bus(1'b1, freq_counter_pkg::OFS_IRQ_MASK, 32'h0, 4'hf);
    bus(1'b1, freq_counter_pkg::OFS_GATE_LIMIT, 32'h1e, 4'hf);
    measure(2'h1, 1'b0, 1'b0);
    rchk("status", freq_counter_pkg::OFS_STATUS, 32'h10c);
    rchk("freq", freq_counter_pkg::OFS_FREQUENCY, 32'h0);
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h2, 4'hf);
    repeat (40) @(posedge clock_in);
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h4, 4'hf);
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h8, 4'hf);
    bus(1'b0, freq_counter_pkg::OFS_COUNT, 32'h0, 4'hf);
    cnt = q;
    chk("started", 32'h1, {31'h0, cnt > 0});
    repeat (20) @(posedge clock_in);
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h8, 4'hf);
    rchk("halted", freq_counter_pkg::OFS_COUNT, cnt);
    trig <= 1'b1;
    bus(1'b1, freq_counter_pkg::OFS_GATE_WIDTH, 32'h1f4, 4'hf);
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h1, 4'hf);
    repeat (15) @(posedge clock_in);
    chk("gate", 32'h1, {31'h0, out1_out});
    bus(1'b1, freq_counter_pkg::OFS_CONTROL, 32'h4, 4'hf);
    bus(1'b0, freq_counter_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk("busy", 32'h0, {31'h0, q[0]});
    results;
  end
endmodule
`default_nettype wire
